/* File: hdl/fg_pkg.sv */
package fg_pkg;
  // ==========================================================
  // Field codes on the nibble bus
  localparam logic [3:0] START_LPC = 4'h0;
  localparam logic [3:0] START_HUB_RD = 4'hd;
  localparam logic [3:0] START_HUB_WR = 4'he;
  localparam logic [1:0] LPC_MEM_TYPE = 2'h1;
  localparam logic [3:0] SIZE_OK = 4'h0;
  localparam logic [3:0] SYNC_READY = 4'h0;
  localparam logic [3:0] TAR_NIB = 4'hf;
  // Address nibble counts, minus one
  localparam logic [2:0] HUB_ADDR_LAST = 3'h6;
  localparam logic [2:0] LPC_ADDR_LAST = 3'h7;
  // Address field positions
  localparam int HUB_ARRAY_BIT = 22;
  localparam int LPC_ARRAY_BIT = 23;
  localparam int LPC_SEL_LSB = 19;
  localparam int ARRAY_AW = 19;
  // Sector numbering
  localparam logic [3:0] SECT_TOP = 4'ha;
  localparam logic [3:0] SECT_TBL_LOW = 4'h7;
  localparam logic [3:0] SECT_7 = 4'h7;
  localparam logic [3:0] SECT_8 = 4'h8;
  localparam logic [3:0] SECT_9 = 4'h9;
  localparam logic [2:0] UPPER_64K = 3'h7;
  // ==========================================================
  // Reset timing at the 20 MHz system clock
  localparam int CLK_MHZ = 20;
  localparam int RECOV_NS = 1000;
  localparam int LATENCY_NS = 1000;
  localparam logic [7:0] RECOV_CYC = 8'((RECOV_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] LATENCY_CYC = 8'((LATENCY_NS * CLK_MHZ + 999) / 1000);
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_SIZE = 4'b0011,
    ST_DATA = 4'b0100,
    ST_TAR = 4'b0101,
    ST_SYNC = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RTAR = 4'b1000,
    ST_SKIP = 4'b1001
  } fg_state_e;
  typedef enum logic [1:0] {
    OP_PROG = 2'b00,
    OP_SECT_ERASE = 2'b01,
    OP_UNI_ERASE = 2'b10
  } fg_op_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic array;
    logic [ARRAY_AW-1:0] addr;
    logic [7:0] data;
  } fg_req_s;
  typedef struct packed {
    logic valid;
    fg_op_e kind;
    logic [ARRAY_AW-1:0] addr;
  } fg_op_s;
endpackage : fg_pkg

/* File: hdl/fg_flash_guard.sv */
`timescale 1ns/100ps
// Operation
// (RL1) Hub select mismatch: ignore, float, standby
// (RL2) Hub: seven address nibbles, decode A23..A0
// (RL3) Hub: A22 picks array or registers
// (RL4) Hub: nonzero size resets, no response
// (RL5) Hub: after valid header, trust everything
// (RL6) LPC: eight address nibbles, decode A23..A0
// (RL7) LPC: A22..A19 compared with straps
// (RL8) LPC: A23 picks array or registers
// (RL9) LPC: after valid header, no command check
// (RL10) Frame low mid-cycle: float, reset machine
// (RL11) Abort never stops running flash operation
// (RL12) Launch only after last data nibble
// (RL13) Host may send stop start code
// (RL14) Reset or init low: deselected, idle
// (RL15) Leaving reset: read array, locks default
// (RL16) Reset during operation: abort, add latency
// (RL17) System must reset device with itself
// (RL18) Boot lock guards top sector, hub 7-10
// (RL19) LPC uniform erase: boot 10-7, wp 6-0
// (RL20) LPC wp blocks erase/program sectors 9-0
// (RL21) Hub wp blocks sectors 6-0
// (RL22) Pins sampled at operation start
// (RL23) Pins override locks, never alter them
// (RL24) Locked target reports sector lock error
// (RL25) Blocked operation leaves array untouched
module fg_flash_guard (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bus pins
  input wire logic cycle_frame_signal_n,
  input wire logic [3:0] nibble_bus_in,
  output logic [3:0] nibble_bus_out,
  output logic nibble_bus_oe,
  input wire logic [3:0] strap_identifier_pins,
  // Reset and protection pins
  input wire logic reset_pin_n,
  input wire logic init_pin_n,
  input wire logic top_boot_lock_pin_n,
  input wire logic write_protect_pin_n,
  // Access path to the command user interface
  output fg_pkg::fg_req_s cui_req,
  input wire logic [7:0] cui_rd_data,
  // Flash operation requests and their verdict
  input wire fg_pkg::fg_op_s op_req,
  input wire logic op_busy,
  input wire logic [10:0] sector_write_lock,
  output logic op_go,
  output logic op_fail,
  output logic lock_error,
  input wire logic lock_error_clr,
  output logic tbl_seen_n,
  output logic wp_seen_n,
  // Device reset outcome
  output logic op_abort,
  output logic restore_defaults,
  output logic deselected,
  output logic cmd_ready,
  output logic standby
);
  import fg_pkg::*;

  // ==========================================================
  // Helpers
  // Sector number from an array address
  function automatic logic [3:0] sector_of(input logic [ARRAY_AW-1:0] a);
    logic [3:0] s;
    s = {1'b0, a[18:16]};
    if (a[18:16] == UPPER_64K)
    begin
      unique case (a[15:13])
        3'h0, 3'h1: s = SECT_7;
        3'h2: s = SECT_8;
        3'h3: s = SECT_9;
        default: s = SECT_TOP;
      endcase
    end
    return s;
  endfunction : sector_of

  // True when the protection pins forbid the operation
  function automatic logic pin_blocked(input logic hub, input fg_op_e kind,
                                       input logic [3:0] sect,
                                       input logic tbl_n, input logic wp_n);
    logic tbl_zone;
    tbl_zone = (hub || kind == OP_UNI_ERASE) ? (sect >= SECT_TBL_LOW)
                                             : (sect == SECT_TOP);
    return tbl_zone ? !tbl_n : !wp_n;
  endfunction : pin_blocked

  // ==========================================================
  // Cycle decoder state
  fg_state_e state;
  logic [3:0] start_q;
  logic hub_mode;
  logic is_write;
  logic [2:0] cnt;
  logic [31:0] addr_q;
  logic [7:0] data_q;
  logic [3:0] rd_hi;
  logic dev_rst_n;
  logic [31:0] next_addr;
  logic cycle_live;
  logic abort_now;
  logic [7:0] lat_cnt;
  logic dev_rst_q;
  logic lat_pend;

  assign dev_rst_n = reset_pin_n & init_pin_n;
  assign next_addr = {addr_q[27:0], nibble_bus_in};
  assign cycle_live = (state != ST_IDLE) && (state != ST_START);
  // Frame low after the start field ends the cycle at once
  assign abort_now = cycle_live && !cycle_frame_signal_n; // RL10

  // Cycle decoder; a frame low restarts start capture so the
  // host's stop code simply lands back in idle
  always_ff @(posedge clk_sys)
  begin
    if (reset || !dev_rst_n) // RL14
    begin
      state <= ST_IDLE;
      start_q <= START_LPC;
      hub_mode <= 1'b0;
      is_write <= 1'b0;
      cnt <= 3'h0;
      addr_q <= 32'h0;
      data_q <= 8'h0;
      rd_hi <= 4'h0;
      nibble_bus_out <= TAR_NIB;
      nibble_bus_oe <= 1'b0;
    end
    else if (abort_now)
    begin
      state <= ST_START; // RL10 RL13
      start_q <= nibble_bus_in;
      nibble_bus_oe <= 1'b0; // RL10
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (!cycle_frame_signal_n)
          begin
            start_q <= nibble_bus_in;
            state <= ST_START;
          end
        end
        ST_START:
        begin
          // Only the last start before frame rises counts
          if (!cycle_frame_signal_n)
            start_q <= nibble_bus_in;
          else if (start_q == START_HUB_RD || start_q == START_HUB_WR)
          begin
            hub_mode <= 1'b1;
            is_write <= (start_q == START_HUB_WR);
            cnt <= HUB_ADDR_LAST; // RL2
            state <= (nibble_bus_in == strap_identifier_pins) ? ST_ADDR
                                                                : ST_SKIP; // RL1
          end
          else if (start_q == START_LPC)
          begin
            hub_mode <= 1'b0;
            is_write <= nibble_bus_in[1];
            cnt <= LPC_ADDR_LAST; // RL6
            state <= (nibble_bus_in[3:2] == LPC_MEM_TYPE) ? ST_ADDR : ST_SKIP;
          end
          else
            state <= ST_IDLE;
        end
        ST_ADDR:
        begin
          addr_q <= next_addr;
          cnt <= cnt - 3'h1;
          if (cnt == 3'h0)
          begin
            if (hub_mode)
              state <= ST_SIZE;
            else if (next_addr[LPC_SEL_LSB+3:LPC_SEL_LSB] != strap_identifier_pins)
              state <= ST_SKIP; // RL7
            else
            begin
              cnt <= 3'h1;
              state <= is_write ? ST_DATA : ST_TAR; // RL9
            end
          end
        end
        ST_SIZE:
        begin
          cnt <= 3'h1;
          if (nibble_bus_in != SIZE_OK)
            state <= ST_IDLE; // RL4
          else
            state <= is_write ? ST_DATA : ST_TAR; // RL5
        end
        ST_DATA:
        begin
          // Low nibble first
          cnt <= 3'h1;
          if (cnt == 3'h1)
          begin
            data_q[3:0] <= nibble_bus_in;
            cnt <= 3'h0;
          end
          else
          begin
            data_q[7:4] <= nibble_bus_in;
            state <= ST_TAR;
          end
        end
        ST_TAR:
        begin
          cnt <= 3'h0;
          if (cnt == 3'h0)
          begin
            state <= ST_SYNC;
            nibble_bus_out <= SYNC_READY;
            nibble_bus_oe <= 1'b1;
          end
        end
        ST_SYNC:
        begin
          if (is_write)
          begin
            nibble_bus_out <= TAR_NIB;
            state <= ST_RTAR;
          end
          else
          begin
            nibble_bus_out <= cui_rd_data[3:0];
            rd_hi <= cui_rd_data[7:4];
            cnt <= 3'h1;
            state <= ST_RDATA;
          end
        end
        ST_RDATA:
        begin
          cnt <= 3'h0;
          nibble_bus_out <= (cnt == 3'h1) ? rd_hi : TAR_NIB;
          if (cnt == 3'h0)
            state <= ST_RTAR;
        end
        ST_RTAR:
        begin
          // Drive ones for one clock, then let go
          nibble_bus_oe <= 1'b0;
          state <= ST_IDLE;
        end
        ST_SKIP:
          state <= ST_SKIP; // RL1
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Access hand-off. Issued in the first turn-around clock, so a
  // frame low as late as the first turn-around nibble suppresses it.
  always_ff @(posedge clk_sys)
  begin
    if (reset || !dev_rst_n)
      cui_req <= '0;
    else
    begin
      cui_req.valid <= (state == ST_TAR) && (cnt == 3'h1) && !abort_now; // RL12
      cui_req.write <= is_write;
      cui_req.array <= hub_mode ? addr_q[HUB_ARRAY_BIT]
                                : addr_q[LPC_ARRAY_BIT]; // RL3 RL8
      cui_req.addr <= addr_q[ARRAY_AW-1:0]; // RL2 RL6
      cui_req.data <= data_q; // RL5 RL9
    end
  end

  // ==========================================================
  // Protection verdict. The abort path never reaches here, so a
  // running operation survives a bus abort.
  logic [3:0] op_sect;
  logic op_pin_block;
  logic op_lock_block;

  assign op_sect = sector_of(op_req.addr);
  assign op_pin_block = pin_blocked(hub_mode, op_req.kind, op_sect,
                                    top_boot_lock_pin_n,
                                    write_protect_pin_n); // RL18 RL19 RL20 RL21
  // Pins and lock bits are ORed; neither feeds the other
  assign op_lock_block = sector_write_lock[op_sect]; // RL23

  always_ff @(posedge clk_sys)
  begin
    if (reset || !dev_rst_n)
    begin
      op_go <= 1'b0;
      op_fail <= 1'b0;
      tbl_seen_n <= 1'b1;
      wp_seen_n <= 1'b1;
    end
    else
    begin
      op_go <= 1'b0; // RL11
      op_fail <= 1'b0;
      if (op_req.valid && !op_busy && cmd_ready)
      begin
        tbl_seen_n <= top_boot_lock_pin_n; // RL22
        wp_seen_n <= write_protect_pin_n; // RL22
        op_go <= !(op_pin_block || op_lock_block); // RL25
        op_fail <= op_pin_block || op_lock_block; // RL23
      end
    end
  end

  // Sticky sector lock error; a new failure beats the clear
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      lock_error <= 1'b0;
    else if (op_fail)
      lock_error <= 1'b1; // RL24
    else if (lock_error_clr)
      lock_error <= 1'b0;
  end

  // ==========================================================
  // Device reset through the reset and init pins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dev_rst_q <= 1'b0;
      lat_pend <= 1'b0;
      lat_cnt <= RECOV_CYC;
      op_abort <= 1'b0;
      restore_defaults <= 1'b0;
    end
    else
    begin
      dev_rst_q <= dev_rst_n;
      op_abort <= dev_rst_q && !dev_rst_n && op_busy; // RL16
      restore_defaults <= dev_rst_n && !dev_rst_q; // RL15
      if (!dev_rst_n)
      begin
        lat_cnt <= RECOV_CYC;
        if (op_busy)
          lat_pend <= 1'b1; // RL16
      end
      else if (!dev_rst_q)
      begin
        // Recovery, lengthened when an operation was cut short
        lat_cnt <= lat_pend ? 8'(RECOV_CYC + LATENCY_CYC) : RECOV_CYC; // RL16
        lat_pend <= 1'b0;
      end
      else if (lat_cnt != 8'h0)
        lat_cnt <= lat_cnt - 8'h1;
    end
  end

  // Status levels
  assign deselected = !dev_rst_n; // RL14
  assign cmd_ready = dev_rst_n && dev_rst_q && (lat_cnt == 8'h0);
  assign standby = ((state == ST_IDLE) || (state == ST_SKIP)) &&
                   cycle_frame_signal_n && !op_busy; // RL1

endmodule : fg_flash_guard

/* File: sim/fg_flash_guard_checker.sv */
`timescale 1ns/100ps
// ==========
// Port checker
module fg_flash_guard_checker
  import fg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins
  input wire logic cycle_frame_signal_n,
  input wire logic nibble_bus_oe,
  input wire logic reset_pin_n,
  input wire logic init_pin_n,
  input wire logic top_boot_lock_pin_n,
  input wire logic write_protect_pin_n,
  // Operation side
  input wire fg_pkg::fg_req_s cui_req,
  input wire fg_pkg::fg_op_s op_req,
  input wire logic op_busy,
  input wire logic cmd_ready,
  input wire logic op_go,
  input wire logic op_fail,
  input wire logic lock_error,
  input wire logic tbl_seen_n,
  input wire logic op_abort,
  input wire logic restore_defaults,
  input wire logic deselected,
  input wire logic standby
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take;
  // An operation that the guard must judge
  assign take = op_req.valid && !op_busy && cmd_ready && !deselected;
  a_deselect_pins: assert property (deselected == !(reset_pin_n && init_pin_n))
    else $error("deselect flag wrong");
  a_float_in_reset: assert property (!(reset_pin_n && init_pin_n) |=> !nibble_bus_oe && !op_go)
    else $error("active while held in reset");
  a_frame_float: assert property (!cycle_frame_signal_n |=> !nibble_bus_oe)
    else $error("driving after frame low");
  a_standby_float: assert property (standby |-> !nibble_bus_oe)
    else $error("driving in standby");
  a_one_verdict: assert property (take |=> op_go != op_fail)
    else $error("no single verdict");
  a_tbl_top: assert property (
    take && !top_boot_lock_pin_n && op_req.addr[18:15] == 4'hf |=> op_fail && !op_go)
    else $error("top sector not guarded");
  a_wp_low: assert property (
    take && !write_protect_pin_n && op_req.addr[18:16] != 3'h7 |=> op_fail)
    else $error("low sectors not guarded");
  // The sticky flag follows the refusal pulse by one clock
  a_lock_flag: assert property (op_fail |=> lock_error)
    else $error("refusal without error flag");
  a_pin_sample: assert property (op_go |-> tbl_seen_n == $past(top_boot_lock_pin_n))
    else $error("pin not sampled at launch");
  // Either reset or init may cut an operation; a bus abort never does
  a_abort_cause: assert property (op_abort |-> $past(deselected))
    else $error("abort without device reset");
  a_abort_op: assert property ($fell(reset_pin_n) && op_busy |-> ##[1:2] op_abort)
    else $error("running operation not aborted");
  // Main scenarios
  c_bus_req: cover property (cui_req.valid);
  c_refused: cover property (op_fail);
  c_aborted: cover property (op_abort);
  c_restored: cover property (restore_defaults);
endmodule : fg_flash_guard_checker

bind fg_flash_guard fg_flash_guard_checker i_fg_flash_guard_checker (
  .clk_sys(clk_sys), .reset(reset), .cycle_frame_signal_n(cycle_frame_signal_n),
  .nibble_bus_oe(nibble_bus_oe), .reset_pin_n(reset_pin_n), .init_pin_n(init_pin_n),
  .top_boot_lock_pin_n(top_boot_lock_pin_n), .write_protect_pin_n(write_protect_pin_n),
  .cui_req(cui_req), .op_req(op_req), .op_busy(op_busy), .cmd_ready(cmd_ready),
  .op_go(op_go), .op_fail(op_fail), .lock_error(lock_error), .tbl_seen_n(tbl_seen_n),
  .op_abort(op_abort), .restore_defaults(restore_defaults), .deselected(deselected),
  .standby(standby)
);

/* File: sim/fg_host_model.sv */
`timescale 1ns/100ps
// ==========
// Host bus controller
module fg_host_model (
  // Clock
  input wire logic clk_sys,
  // Bus
  input wire logic [3:0] nibble_bus_in,
  input wire logic nibble_bus_oe,
  output logic cycle_frame_signal_n,
  output logic [3:0] host_nib,
  output logic host_drv
);
  logic [3:0] sync_nib;
  logic sync_oe;
  logic tail_oe;
  // Bus idle with frame high
  initial
  begin
    cycle_frame_signal_n = 1'b1;
    host_nib = 4'hf;
    host_drv = 1'b0;
  end
  // One cycle; nibble ab is replaced by a stop code with frame low
  task send(input logic [3:0] nib [$], input int ab);
    for (int i = 0; i <= ab && i < nib.size(); i++)
    begin
      @(posedge clk_sys);
      host_drv <= 1'b1;
      cycle_frame_signal_n <= !(i == 0 || i == ab);
      host_nib <= (i == ab) ? 4'hf : nib[i];
    end
    // Turn-around, then let the pull-ups hold the lines
    @(posedge clk_sys);
    cycle_frame_signal_n <= 1'b1;
    host_nib <= 4'hf;
    @(posedge clk_sys);
    host_drv <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    sync_nib = nibble_bus_in;
    sync_oe = nibble_bus_oe;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    tail_oe = nibble_bus_oe;
  endtask : send
endmodule : fg_host_model

/* File: sim/fg_flash_guard_tb_top.sv */
`timescale 1ns/100ps
// ==========
// Testbench
module fg_flash_guard_tb_top;
  import fg_pkg::*;
  logic clk_sys, reset, frame_n, nib_oe, rst_n, init_n, tbl_n, wp_n, busy, clr;
  logic op_go, op_fail, lock_error, tbl_seen_n, op_abort, restore, desel, ready, standby;
  logic host_drv;
  logic [3:0] nib_in, nib_out, host_nib;
  logic [10:0] locks;
  logic [2:0] evt;
  fg_req_s cui_req, cui_last;
  fg_op_s op_req;
  int fail_count, comparisons, cui_hits;
  // Released lines float up to all ones
  assign nib_in = nib_oe ? nib_out : (host_drv ? host_nib : 4'hf);
  assign evt = {ready, restore, op_abort};
  fg_flash_guard i_fg_flash_guard (
    .clk_sys(clk_sys), .reset(reset), .cycle_frame_signal_n(frame_n),
    .nibble_bus_in(nib_in), .nibble_bus_out(nib_out), .nibble_bus_oe(nib_oe),
    .strap_identifier_pins(4'h5), .reset_pin_n(rst_n), .init_pin_n(init_n),
    .top_boot_lock_pin_n(tbl_n), .write_protect_pin_n(wp_n), .cui_req(cui_req),
    .cui_rd_data(8'h00), .op_req(op_req), .op_busy(busy), .sector_write_lock(locks),
    .op_go(op_go), .op_fail(op_fail), .lock_error(lock_error), .lock_error_clr(clr),
    .tbl_seen_n(tbl_seen_n), .wp_seen_n(), .op_abort(op_abort), .restore_defaults(restore),
    .deselected(desel), .cmd_ready(ready), .standby(standby)
  );
  fg_host_model i_fg_host_model (
    .clk_sys(clk_sys), .nibble_bus_in(nib_in), .nibble_bus_oe(nib_oe),
    .cycle_frame_signal_n(frame_n), .host_nib(host_nib), .host_drv(host_drv)
  );
  // Count and keep each request towards the core
  always @(posedge clk_sys)
    if (cui_req.valid === 1'b1)
    begin
      cui_hits++;
      cui_last <= cui_req;
    end
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task print_verdict();
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Bounded wait; running out ends the run
  task wait_hi(input int b, input int n);
    for (int i = 0; i < n && evt[b] !== 1'b1; i++) @(posedge clk_sys);
    check(evt[b], 1'b1);
    if (evt[b] !== 1'b1) print_verdict();
  endtask : wait_hi
  // Address MSN first, data low nibble first; an of 7 means a hub cycle
  task bus(input logic [3:0] st, input logic [3:0] hd, input logic [31:0] a, input int an,
    input logic [3:0] sz, input int ab, input int hits);
    logic [3:0] q [$];
    q = {st, hd};
    for (int i = an - 1; i >= 0; i--) q.push_back(a[i*4 +: 4]);
    if (an == 7) q.push_back(sz);
    q.push_back(4'h3);
    q.push_back(4'hc);
    cui_hits = 0;
    i_fg_host_model.send(q, ab);
    check(cui_hits, hits);
    check(i_fg_host_model.sync_oe, hits);
    check(i_fg_host_model.tail_oe, 1'b0);
    if (hits == 1) check(i_fg_host_model.sync_nib, SYNC_READY);
  endtask : bus
  // LPC read: sync ready, low nibble, high nibble still driven at tail
  task t_read();
    logic [3:0] q [$];
    q = {START_LPC, 4'h4, 4'hf, 4'hf, 4'ha, 4'h9, 4'h2, 4'h3, 4'h4, 4'h5};
    cui_hits = 0;
    i_fg_host_model.send(q, 99);
    check(cui_hits, 1);
    check({i_fg_host_model.sync_oe, i_fg_host_model.sync_nib, i_fg_host_model.tail_oe}, 6'h21);
    check({cui_last.write, cui_last.array}, 2'h1);
    // Let the device finish its turn-around before the next frame
    repeat (2) @(posedge clk_sys);
  endtask : t_read
  task cui_chk(input logic arr);
    check({cui_last.write, cui_last.array, cui_last.addr}, {2'h1, arr, 19'h12345});
    check(cui_last.data, 8'hc3);
  endtask : cui_chk
  task op(input fg_op_e k, input logic [18:0] a, input logic t, input logic w,
    input logic [10:0] lk, input logic g);
    @(posedge clk_sys);
    op_req <= '{1'b1, k, a};
    tbl_n <= t;
    wp_n <= w;
    locks <= lk;
    @(posedge clk_sys);
    op_req.valid <= 1'b0;
    @(negedge clk_sys);
    check({op_go, op_fail, tbl_seen_n}, {g, !g, t});
  endtask : op
  // Reset pin during an operation, then init pin alone
  task t_reset();
    @(posedge clk_sys);
    busy <= 1'b1;
    rst_n <= 1'b0;
    wait_hi(0, 5);
    check({desel, nib_oe}, 2'h2);
    @(posedge clk_sys);
    busy <= 1'b0;
    rst_n <= 1'b1;
    wait_hi(1, 5);
    wait_hi(2, 60);
    init_n <= 1'b0;
    @(negedge clk_sys);
    check({desel, ready}, 2'h2);
    @(posedge clk_sys);
    init_n <= 1'b1;
    wait_hi(2, 60);
  endtask : t_reset
  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial
  begin
    {reset, rst_n, init_n, tbl_n, wp_n} = 5'h1f;
    {busy, clr, locks, op_req} = '0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    wait_hi(2, 60);
    bus(START_HUB_WR, 4'h5, 32'hf412345, 7, SIZE_OK, 99, 1);
    cui_chk(1'b1);
    bus(START_HUB_WR, 4'h5, 32'hf012345, 7, SIZE_OK, 99, 1);
    cui_chk(1'b0);
    bus(START_HUB_WR, 4'h6, 32'hf412345, 7, SIZE_OK, 99, 0);
    check(standby, 1'b1);
    bus(START_HUB_WR, 4'h5, 32'hf412345, 7, 4'h1, 99, 0);
    op(OP_PROG, 19'h76000, 1'b0, 1'b1, 11'h0, 1'b0);
    op(OP_PROG, 19'h76000, 1'b1, 1'b0, 11'h0, 1'b1);
    op(OP_SECT_ERASE, 19'h60000, 1'b1, 1'b0, 11'h0, 1'b0);
    bus(START_LPC, 4'h6, 32'hffa92345, 8, SIZE_OK, 99, 1);
    cui_chk(1'b1);
    bus(START_LPC, 4'h6, 32'hffe92345, 8, SIZE_OK, 99, 0);
    t_read();
    bus(START_LPC, 4'h6, 32'hffa92345, 8, SIZE_OK, 11, 0);
    bus(START_LPC, 4'h6, 32'hffa92345, 8, SIZE_OK, 2, 0);
    op(OP_PROG, 19'h78000, 1'b0, 1'b1, 11'h0, 1'b0);
    op(OP_PROG, 19'h78000, 1'b1, 1'b0, 11'h0, 1'b1);
    op(OP_PROG, 19'h76000, 1'b1, 1'b0, 11'h0, 1'b0);
    op(OP_PROG, 19'h76000, 1'b0, 1'b1, 11'h0, 1'b1);
    op(OP_SECT_ERASE, 19'h70000, 1'b1, 1'b0, 11'h0, 1'b0);
    op(OP_UNI_ERASE, 19'h70000, 1'b0, 1'b1, 11'h0, 1'b0);
    op(OP_UNI_ERASE, 19'h70000, 1'b1, 1'b0, 11'h0, 1'b1);
    op(OP_UNI_ERASE, 19'h50000, 1'b1, 1'b0, 11'h0, 1'b0);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    @(negedge clk_sys);
    check(lock_error, 1'b0);
    op(OP_PROG, 19'h50000, 1'b1, 1'b1, 11'h020, 1'b0);
    // The flag is set one clock after the refusal pulse
    @(negedge clk_sys);
    check(lock_error, 1'b1);
    op(OP_PROG, 19'h50000, 1'b1, 1'b1, 11'h0, 1'b1);
    t_reset();
    print_verdict();
  end
endmodule : fg_flash_guard_tb_top
